// ==== acrr_consts.svh ====
// Summary of operation
// - Converter runs only while enable set; cleared
// - Rate bit zero continuous, one one-shot
// - Resolution field selects eleven to eight bits
// - Averaging bit selects single or running average of input current; battery current is never averaged
// - Seed selects existing result or fresh conversion
// - External input channel skipped when bit set
// - Channel-disable bits exclude each listed channel
// - Input current reported signed in bits 15:1
// - Input current clamped 7830h..7D0h, resets zero
`ifndef ACRR_CONSTS_SVH
`define ACRR_CONSTS_SVH
// =====================================================
// Register offsets
`define ACRR_OFF_CONFIG 8'h2b
`define ACRR_OFF_CHOFF 8'h2c
`define ACRR_OFF_IIN_LO 8'h2d
`define ACRR_OFF_IIN_HI 8'h2e
`define ACRR_OFF_IBAT_LO 8'h2f
`define ACRR_OFF_IBAT_HI 8'h30
// =====================================================
// Field positions and reset values
`define ACRR_BIT_EN 7
`define ACRR_BIT_RATE 6
`define ACRR_BIT_AVG 3
`define ACRR_BIT_SEED 2
`define ACRR_BIT_EXT 0
`define ACRR_CONFIG_RESET 8'h30
`define ACRR_CONFIG_WMASK 8'hfd
`define ACRR_CHOFF_RESET 8'h00
// =====================================================
// Input current clamp limits, 15-bit two's complement
`define ACRR_IIN_MIN 15'h7830
`define ACRR_IIN_MAX 15'h07d0
// Conversion time per channel in cycles at resolution 11 bits
`define ACRR_CONV_BASE 8'h0_80
`define ACRR_NUM_CH 4'h9
`endif

// ==== acrr_pkg.sv ====
package acrr_pkg;
	// Sequencer states
	typedef enum logic [1:0] {ACRR_IDLE, ACRR_CONV, ACRR_DONE} acrr_state_e;
	// Host register write strobe with data
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] data;
	} acrr_wr_s;
	// Result sample from the analog core
	typedef struct packed {
		logic valid;
		logic [3:0] ch;
		logic [15:0] code;
	} acrr_sample_s;
endpackage

// ==== acrr_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "acrr_consts.svh"
module acrr_top
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_n_in,
	// Resets from the rest of the charger
	input wire logic reg_defaults_reset_in,
	input wire logic host_timeout_in,
	// Register access from the serial interface logic
	input wire acrr_pkg::acrr_wr_s wr_in,
	input wire logic [7:0] rd_addr_in,
	output logic [7:0] rd_data_out,
	// One-shot request from software
	input wire logic oneshot_req_in,
	// Raw sample from the analog core
	input wire acrr_pkg::acrr_sample_s sample_in,
	// Converter controls
	output logic conv_run_out,
	output logic [3:0] conv_ch_out,
	output logic [1:0] resolution_sel_out,
	output logic [7:0] input_current_reading_lo_out
);
	// =====================================================
	// State
	// All state takes its reset value on the synchronous reset; the defaults reset and
	// the host timeout act through the next values, so every register
	// keeps a single driver.
	// Results are read-only to the host and change only on a sample.
	logic [7:0] adc_config, next_adc_config; // Control register
	logic [7:0] adc_channel_off_mask, next_adc_channel_off_mask; // Channel disables
	logic [14:0] input_current_result, next_input_current_result; // Signed result
	logic [12:0] battery_current_result, next_battery_current_result; // Signed result
	logic seeded, next_seeded; // Average has a start value
	acrr_pkg::acrr_state_e state, next_state; // Sequencer
	logic [3:0] ch, next_ch; // Channel being converted
	logic [7:0] rd_data, next_rd_data; // Read data
	logic run, next_run; // Converter running

	// Clamp a 15-bit signed code into the reportable range
	// Codes past either limit would otherwise read back as a wrapped
	// value of the wrong sign.
	function automatic logic [14:0] clamp_iin(input logic [14:0] v);
		if ($signed(v) < $signed(`ACRR_IIN_MIN))
			clamp_iin = `ACRR_IIN_MIN;
		else if ($signed(v) > $signed(`ACRR_IIN_MAX))
			clamp_iin = `ACRR_IIN_MAX;
		else
			clamp_iin = v;
	endfunction

	// Channel off test: 0..7 from the mask (bit 7 first), 8 external
	// Channel numbers follow the sweep order, so mask bit 7 is the
	// first channel and the external input comes last.
	function automatic logic ch_off(input logic [3:0] c, input logic [7:0] m, input logic e);
		if (c == 4'h8)
			ch_off = e;
		else
			ch_off = m[3'(4'h7 - c)];
	endfunction

	// =====================================================
	// Next-state logic for registers, sequencer and results
	// Later assignments in this process override earlier ones, which
	// gives the resets priority over host writes and the sequencer.
	always_comb
	begin
		logic [14:0] raw;
		// Clamped input current code from the reading's field
		raw = clamp_iin(sample_in.code[15:1]);
		next_adc_config = adc_config;
		next_adc_channel_off_mask = adc_channel_off_mask;
		next_input_current_result = input_current_result;
		next_battery_current_result = battery_current_result;
		next_seeded = seeded;
		next_state = state;
		next_ch = ch;
		next_run = 1'b0;
		// Host writes, reserved bit 1 kept zero
		// A config write restarts the averaging seed choice.
		if (wr_in.wr && wr_in.addr == `ACRR_OFF_CONFIG)
		begin
			next_adc_config = wr_in.data & `ACRR_CONFIG_WMASK;
			next_seeded = 1'b0;
		end
		else if (wr_in.wr && wr_in.addr == `ACRR_OFF_CHOFF)
		begin
			next_adc_channel_off_mask = wr_in.data;
		end
		// Sequencer
		// A sweep visits channels 0 to 8 in turn; a disabled channel costs
		// one cycle, an enabled one waits for its sample from the core.
		// A sample for any other channel is ignored.
		case (state)
			acrr_pkg::ACRR_IDLE:
			begin
				// Continuous starts at once, one-shot waits for a request
				if (adc_config[`ACRR_BIT_EN] &&
					(!adc_config[`ACRR_BIT_RATE] || oneshot_req_in))
				begin
					next_state = acrr_pkg::ACRR_CONV;
					next_ch = 4'h0;
				end
			end
			acrr_pkg::ACRR_CONV:
			begin
				next_run = !ch_off(ch, adc_channel_off_mask, adc_config[`ACRR_BIT_EXT]);
				// Skipped channel or finished sample moves on
				// Only the two current channels have result registers here.
				if (!next_run || (sample_in.valid && sample_in.ch == ch))
				begin
					if (next_run && ch == 4'h0)
					begin
						// Running average or single value
						// The sum is one bit wider, so it cannot overflow.
						if (adc_config[`ACRR_BIT_AVG] && (seeded || !adc_config[`ACRR_BIT_SEED]))
							next_input_current_result = 15'(($signed({input_current_result[14], input_current_result}) + $signed({raw[14], raw})) >>> 1);
						else
							next_input_current_result = raw;
						next_seeded = 1'b1;
					end
					else if (next_run && ch == 4'h1)
						next_battery_current_result = sample_in.code[15:3];
					next_run = 1'b0;
					if (ch == `ACRR_NUM_CH - 4'h1)
						next_state = adc_config[`ACRR_BIT_RATE] ? acrr_pkg::ACRR_DONE : acrr_pkg::ACRR_IDLE;
					else
						next_ch = ch + 4'h1;
				end
			end
			default:
			begin
				// One-shot sweep over: wait in idle for the next request
				// Enable stays set, so a new request needs no rewrite.
				next_state = acrr_pkg::ACRR_IDLE;
			end
		endcase
		// Clearing enable abandons a sweep at once
		if (!adc_config[`ACRR_BIT_EN])
		begin
			next_state = acrr_pkg::ACRR_IDLE;
			next_run = 1'b0;
		end
		// Defaults reset and host timeout
		// The defaults reset wins over a host write in the same cycle;
		// the timeout clears only the enable bit.
		if (reg_defaults_reset_in)
		begin
			next_adc_config = `ACRR_CONFIG_RESET;
			next_adc_channel_off_mask = `ACRR_CHOFF_RESET;
			next_state = acrr_pkg::ACRR_IDLE;
			next_run = 1'b0;
		end
		else if (host_timeout_in)
		begin
			next_adc_config[`ACRR_BIT_EN] = 1'b0;
			next_state = acrr_pkg::ACRR_IDLE;
			next_run = 1'b0;
		end
		// Read mux
		// Read data is registered and answers one cycle after the address.
		// Reserved low bits read as zero; unmapped addresses read 0x00.
		if (rd_addr_in == `ACRR_OFF_CONFIG)
			next_rd_data = adc_config;
		else if (rd_addr_in == `ACRR_OFF_CHOFF)
			next_rd_data = adc_channel_off_mask;
		else if (rd_addr_in == `ACRR_OFF_IIN_LO)
			next_rd_data = {input_current_result[6:0], 1'b0};
		else if (rd_addr_in == `ACRR_OFF_IIN_HI)
			next_rd_data = input_current_result[14:7];
		else if (rd_addr_in == `ACRR_OFF_IBAT_LO)
			next_rd_data = {battery_current_result[4:0], 3'b000};
		else if (rd_addr_in == `ACRR_OFF_IBAT_HI)
			next_rd_data = battery_current_result[12:5];
		else
			next_rd_data = 8'h00;
	end

	// =====================================================
	// Registers
	// Plain registers only; every next value comes from the process above.
	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
		begin
			// Power-on values, results read zero
			adc_config <= `ACRR_CONFIG_RESET;
			adc_channel_off_mask <= `ACRR_CHOFF_RESET;
			input_current_result <= 15'h0000;
			battery_current_result <= 13'h0000;
			seeded <= 1'b0;
			state <= acrr_pkg::ACRR_IDLE;
			ch <= 4'h0;
			rd_data <= 8'h00;
			run <= 1'b0;
		end
		else
		begin
			// Take the next values
			adc_config <= next_adc_config;
			adc_channel_off_mask <= next_adc_channel_off_mask;
			input_current_result <= next_input_current_result;
			battery_current_result <= next_battery_current_result;
			seeded <= next_seeded;
			state <= next_state;
			ch <= next_ch;
			rd_data <= next_rd_data;
			run <= next_run;
		end
	end

	// =====================================================
	// Outputs
	// Each output is a register bit or a constant zero bit, so nothing
	// combinational reaches a pin.
	// The low byte of the input current reading is mirrored for the core.
	assign rd_data_out = rd_data;
	assign conv_run_out = run;
	assign conv_ch_out = ch;
	assign resolution_sel_out = adc_config[5:4];
	assign input_current_reading_lo_out = {input_current_result[6:0], 1'b0};
endmodule
`default_nettype wire

// ==== acrr_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// =====
// Analog core stand-in: a sample comes every fourth cycle of run
module acrr_core_model
(
	// Clock
	input wire logic clk_in,
	// Converter controls and the code to return
	input wire logic run_in,
	input wire logic [3:0] ch_in,
	input wire logic [15:0] code_in,
	// Sample to the block
	output var acrr_pkg::acrr_sample_s sample_out
);
	logic [1:0] cnt = 2'h0;
	initial sample_out = '0;
	always @(posedge clk_in)
	begin
		cnt <= run_in ? cnt + 2'h1 : 2'h0;
		// A sample after four cycles of run; otherwise a wrong, changing pattern
		if (run_in && cnt == 2'h3)
			sample_out <= '{1'b1, ch_in, code_in};
		else
			sample_out <= '{1'b0, ~ch_in, ~sample_out.code};
	end
endmodule
`default_nettype wire

// ==== acrr_top_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
// =====
// Port checker
module acrr_top_chk
(
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic reg_defaults_reset_in,
	input wire logic host_timeout_in,
	input wire acrr_pkg::acrr_wr_s wr_in,
	input wire logic [7:0] rd_addr_in,
	input wire logic [7:0] rd_data_out,
	input wire logic conv_run_out,
	input wire logic [3:0] conv_ch_out,
	input wire logic [1:0] resolution_sel_out,
	input wire logic [7:0] input_current_reading_lo_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	a_timeout_stops_run: assert property (host_timeout_in |-> ##[1:3] !conv_run_out)
		else $error("run kept after timeout");
	a_defaults_idle: assert property (reg_defaults_reset_in |-> ##[1:2] !conv_run_out)
		else $error("run kept after defaults");
	a_defaults_res: assert property (reg_defaults_reset_in |-> ##[1:2] resolution_sel_out == 2'b11)
		else $error("resolution not restored");
	a_write_res: assert property (wr_in.wr && wr_in.addr == 8'h2b && !reg_defaults_reset_in
		|=> resolution_sel_out == $past(wr_in.data[5:4]))
		else $error("resolution not written");
	a_reserved_zero: assert property (rd_addr_in == 8'h2b |=> rd_data_out[1] == 1'b0)
		else $error("reserved bit set");
	a_unmapped_zero: assert property (rd_addr_in < 8'h2b || rd_addr_in > 8'h30
		|=> rd_data_out == 8'h00)
		else $error("unmapped read not zero");
	a_channel_range: assert property (conv_ch_out <= 4'h8)
		else $error("channel out of range");
	a_lsb_clear: assert property (rd_addr_in == 8'h2d |=> rd_data_out[0] == 1'b0)
		else $error("reading bit 0 set");
	a_update_needs_run: assert property ($changed(input_current_reading_lo_out)
		|-> $past(conv_run_out))
		else $error("result changed while idle");
	a_result_ro: assert property (wr_in.wr && wr_in.addr == 8'h2d && !conv_run_out
		|=> $stable(input_current_reading_lo_out))
		else $error("reading written");
endmodule
bind acrr_top acrr_top_chk u_chk (.clk_in(clk_in), .reset_n_in(reset_n_in),
	.reg_defaults_reset_in(reg_defaults_reset_in), .host_timeout_in(host_timeout_in),
	.wr_in(wr_in), .rd_addr_in(rd_addr_in), .rd_data_out(rd_data_out),
	.conv_run_out(conv_run_out), .conv_ch_out(conv_ch_out),
	.resolution_sel_out(resolution_sel_out),
	.input_current_reading_lo_out(input_current_reading_lo_out));
`default_nettype wire

// ==== test_acrr_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// =====
// Register and sequencer bench
module test_acrr_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic dflt = 1'b0;
	logic tmo = 1'b0;
	logic shot = 1'b0;
	acrr_pkg::acrr_wr_s wr = '0;
	logic [7:0] ra = 8'h00;
	logic [7:0] rd;
	logic run;
	logic [3:0] ch;
	logic [1:0] res;
	logic [7:0] lo;
	logic [15:0] code = 16'h0000;
	acrr_pkg::acrr_sample_s smp;
	int miscompares = 0;
	int check_count = 0;
	int cycles = 0;
	always #5 clk = ~clk;
	acrr_top dut (.clk_in(clk), .reset_n_in(rst_n), .reg_defaults_reset_in(dflt),
		.host_timeout_in(tmo), .wr_in(wr), .rd_addr_in(ra), .rd_data_out(rd),
		.oneshot_req_in(shot), .sample_in(smp), .conv_run_out(run), .conv_ch_out(ch),
		.resolution_sel_out(res), .input_current_reading_lo_out(lo));
	acrr_core_model core (.clk_in(clk), .run_in(run), .ch_in(ch), .code_in(code),
		.sample_out(smp));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk) wr = '{1'b1, a, d};
		@(negedge clk) wr.wr = 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk) ra = a;
		@(negedge clk) chk(rd, exp);
	endtask
	task automatic shot_sweep;
		@(negedge clk) shot = 1'b1;
		@(negedge clk) shot = 1'b0;
		repeat (30) @(negedge clk);
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Hang guard
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			miscompares++;
			end_sim();
		end
	end
	initial
	begin
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		rd_reg(8'h2b, 8'h30);
		rd_reg(8'h2c, 8'h00);
		rd_reg(8'h2d, 8'h00);
		rd_reg(8'h40, 8'h00);
		chk({6'h00, res}, 8'h03);
		$display("test reset done");
		wr_reg(8'h2b, 8'hff);
		rd_reg(8'h2b, 8'hfd);
		@(negedge clk) tmo = 1'b1;
		@(negedge clk) tmo = 1'b0;
		rd_reg(8'h2b, 8'h7d);
		wr_reg(8'h2c, 8'hff);
		@(negedge clk) dflt = 1'b1;
		@(negedge clk) dflt = 1'b0;
		rd_reg(8'h2b, 8'h30);
		rd_reg(8'h2c, 8'h00);
		wr_reg(8'h2d, 8'hff);
		rd_reg(8'h2d, 8'h00);
		$display("test config done");
		wr_reg(8'h2c, 8'h7f);
		code = 16'h7fff;
		wr_reg(8'h2b, 8'h81);
		repeat (20) @(negedge clk);
		rd_reg(8'h2d, 8'ha0);
		rd_reg(8'h2e, 8'h0f);
		code = 16'h8000;
		repeat (20) @(negedge clk);
		rd_reg(8'h2d, 8'h60);
		rd_reg(8'h2e, 8'hf0);
		$display("test clamp done");
		wr_reg(8'h2b, 8'hc1);
		repeat (20) @(negedge clk);
		chk({7'h00, run}, 8'h00);
		code = 16'h0004;
		@(negedge clk) shot = 1'b1;
		@(negedge clk) shot = 1'b0;
		repeat (20) @(negedge clk);
		rd_reg(8'h2d, 8'h04);
		chk({7'h00, run}, 8'h00);
		code = 16'h0010;
		repeat (20) @(negedge clk);
		rd_reg(8'h2d, 8'h04);
		$display("test one-shot done");
		// Average with the held value, then seeded by a fresh sample
		wr_reg(8'h2b, 8'he9);
		code = 16'h0014;
		shot_sweep();
		rd_reg(8'h2d, 8'h0c);
		wr_reg(8'h2b, 8'hed);
		code = 16'h0028;
		shot_sweep();
		rd_reg(8'h2d, 8'h28);
		code = 16'h0008;
		shot_sweep();
		rd_reg(8'h2d, 8'h18);
		chk(lo, 8'h18);
		chk({6'h00, res}, 8'h02);
		$display("test average done");
		// Only the external channel converts
		wr_reg(8'h2c, 8'hff);
		wr_reg(8'h2b, 8'hc0);
		code = 16'h0040;
		@(negedge clk) shot = 1'b1;
		@(negedge clk) shot = 1'b0;
		repeat (11) @(negedge clk);
		chk({3'b000, run, ch}, 8'h18);
		repeat (20) @(negedge clk);
		rd_reg(8'h2d, 8'h18);
		// Battery current on, input current still off
		wr_reg(8'h2c, 8'hbf);
		code = 16'h1234;
		shot_sweep();
		rd_reg(8'h2f, 8'h30);
		rd_reg(8'h30, 8'h12);
		rd_reg(8'h2d, 8'h18);
		$display("test channels done");
		end_sim();
	end
endmodule
`default_nettype wire
